// file: core/charger_monitor_pkg.sv
// constants for the charger monitor register slice
`default_nettype none
package charger_monitor_pkg;
  localparam int          REG_ADDR_W          = 8;
  localparam int          REG_DATA_W          = 8;
  localparam int          CODE_W              = 7;
  localparam logic [7:0]  INPUT_VOLTAGE_FLOOR_CONFIG   = 8'h0D;
  localparam logic [7:0]  BATTERY_VOLTAGE_THERMAL_STATUS = 8'h0E;
  localparam logic [7:0]  SYSTEM_VOLTAGE_RESULT  = 8'h0F;
  localparam logic [7:0]  RESERVED_SLOT          = 8'h10;
  localparam logic [7:0]  INPUT_VOLTAGE_ATTACH_STATUS = 8'h11;
  localparam int          SELECT_BIT          = 7;
  localparam int          FLAG_BIT            = 7;
  localparam logic        SELECT_RESET        = 1'h0;
  localparam logic [6:0]  FLOOR_RESET         = 7'h12;
  localparam logic [7:0]  RESERVED_READ       = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ       = 8'h00;
  // absolute floor in mV: offset plus code times step
  localparam logic [15:0] FLOOR_OFFSET_MV     = 16'h0A28;
  localparam logic [15:0] FLOOR_STEP_MV       = 16'h0064;
endpackage : charger_monitor_pkg
`default_nettype wire

// file: core/input_floor_select.sv
// input voltage floor source selection and absolute millivolt conversion
`default_nettype none
module input_floor_select
  import charger_monitor_pkg::*;
(
  input  wire logic        absolute_threshold_select,
  input  wire logic [6:0]  input_voltage_floor,
  input  wire logic [15:0] relative_floor_mv,
  output logic [15:0]      floor_target_mv,
  output logic             floor_is_absolute
);
  function automatic logic [15:0] code_to_mv(input logic [6:0] code);
    code_to_mv = 16'(FLOOR_OFFSET_MV + 16'(code) * FLOOR_STEP_MV);
  endfunction : code_to_mv

  always_comb begin
    floor_is_absolute = absolute_threshold_select;
    if (absolute_threshold_select) begin
      floor_target_mv = code_to_mv(input_voltage_floor); // see RULE2
    end else begin
      floor_target_mv = relative_floor_mv; // see RULE1
    end
  end
endmodule : input_floor_select
`default_nettype wire

// file: core/charger_monitor_registers.sv
// register slice: input floor setting and converter readings
// Summary of operation
// RULE1: select bit 0 uses relative floor, ignores absolute field; 0 after reset.
// RULE2: select bit 1 uses absolute floor 2.6 V plus code times 100 mV.
// RULE3: input plug-in reloads select bit and floor field with defaults.
// RULE4: battery result bit 7 shows thermal regulation.
// RULE5: input result bit 7 shows input supply attached.
// RULE6: input voltage reading is a read-only 7-bit code in bits 6:0.
// RULE7: battery and system readings are read-only 7-bit codes in bits 6:0.
// RULE8: register reset trigger restores floor defaults and restarts the safety timer.
`default_nettype none
module charger_monitor_registers
  import charger_monitor_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  input  wire logic [REG_ADDR_W-1:0] reg_addr,
  input  wire logic [REG_DATA_W-1:0] reg_wdata,
  output logic      [REG_DATA_W-1:0] reg_rdata,
  input  wire logic                  register_reset,
  input  wire logic                  input_plugged,
  input  wire logic                  thermal_regulation,
  input  wire logic                  input_attached_flag,
  input  wire logic [CODE_W-1:0]     battery_voltage_code,
  input  wire logic [CODE_W-1:0]     system_voltage_result,
  input  wire logic [CODE_W-1:0]     input_voltage_result,
  input  wire logic [15:0]           relative_floor_mv,
  output logic      [15:0]           floor_target_mv,
  output logic                       floor_is_absolute,
  output logic                       safety_timer_restart
);
  typedef struct packed {
    logic             absolute_threshold_select;
    logic [6:0]       input_voltage_floor;
    logic             plugged_prev;
    logic             timer_restart;
    logic [7:0]       rdata;
  } state_s;

  state_s state;
  state_s next_state;
  logic   plug_event;
  logic   defaults_load;

  // a result register must hold one 7-bit code and one flag bit
  if (REG_DATA_W != CODE_W + 1) begin : g_width_check
    $error("register width must hold one code and one flag");
  end

  assign plug_event = input_plugged && !state.plugged_prev;
  assign defaults_load = register_reset || plug_event;

  // true when a write strobe targets the floor setting
  function automatic logic floor_write(input logic wr, input logic [REG_ADDR_W-1:0] addr);
    floor_write = wr && (addr == INPUT_VOLTAGE_FLOOR_CONFIG);
  endfunction : floor_write

  // read data for one address; converter codes and flags pass straight through
  function automatic logic [7:0] read_mux(
    input logic [REG_ADDR_W-1:0] addr,
    input state_s                s,
    input logic                  thermal,
    input logic                  attached,
    input logic [CODE_W-1:0]     bat_code,
    input logic [CODE_W-1:0]     sys_code,
    input logic [CODE_W-1:0]     vin_code
  );
    case (addr)
      INPUT_VOLTAGE_FLOOR_CONFIG:     read_mux = {s.absolute_threshold_select, s.input_voltage_floor};
      BATTERY_VOLTAGE_THERMAL_STATUS: read_mux = {thermal, bat_code}; // see RULE4
      SYSTEM_VOLTAGE_RESULT:          read_mux = {1'h0, sys_code}; // see RULE7
      RESERVED_SLOT:                  read_mux = RESERVED_READ;
      INPUT_VOLTAGE_ATTACH_STATUS:    read_mux = {attached, vin_code}; // see RULE5
      default:                        read_mux = UNMAPPED_READ;
    endcase
  endfunction : read_mux

  always_comb begin
    next_state = state;
    next_state.plugged_prev = input_plugged;
    next_state.timer_restart = register_reset; // see RULE8
    if (floor_write(reg_write, reg_addr)) begin
      next_state.absolute_threshold_select = reg_wdata[SELECT_BIT];
      next_state.input_voltage_floor = reg_wdata[CODE_W-1:0];
    end
    // a reload in the same cycle as a write wins over the write
    if (defaults_load) begin
      next_state.absolute_threshold_select = SELECT_RESET; // see RULE3
      next_state.input_voltage_floor = FLOOR_RESET; // see RULE8
    end
    if (reg_read) begin
      next_state.rdata = read_mux(reg_addr, state, thermal_regulation, input_attached_flag,
                                  battery_voltage_code, system_voltage_result, input_voltage_result); // see RULE6
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= '{absolute_threshold_select: SELECT_RESET, input_voltage_floor: FLOOR_RESET,
                 plugged_prev: 1'h0, timer_restart: 1'h0, rdata: 8'h00};
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign safety_timer_restart = state.timer_restart;

  input_floor_select u_floor (
    .absolute_threshold_select (state.absolute_threshold_select),
    .input_voltage_floor       (state.input_voltage_floor),
    .relative_floor_mv         (relative_floor_mv),
    .floor_target_mv           (floor_target_mv),
    .floor_is_absolute         (floor_is_absolute)
  );

  // building blocks for the properties below
  sequence plug_seq;
    input_plugged && !state.plugged_prev;
  endsequence

  sequence defaults_seq;
    !state.absolute_threshold_select && state.input_voltage_floor == FLOOR_RESET;
  endsequence

  sequence floor_write_seq;
    floor_write(reg_write, reg_addr) && !defaults_load;
  endsequence

  sequence other_write_seq;
    reg_write && !floor_write(reg_write, reg_addr) && !defaults_load;
  endsequence

  property relative_prop;
    @(posedge clk) disable iff (!nrst)
      !state.absolute_threshold_select |-> floor_target_mv == relative_floor_mv;
  endproperty
  a_relative_mode: assert property (relative_prop) // see RULE1
    else $error("relative floor not used");

  property reset_defaults_prop;
    @(posedge clk)
      !nrst |=> !state.absolute_threshold_select && state.input_voltage_floor == FLOOR_RESET && !safety_timer_restart;
  endproperty
  a_reset_defaults: assert property (reset_defaults_prop) // see RULE1
    else $error("reset defaults wrong");

  property config_read_prop;
    @(posedge clk) disable iff (!nrst)
      reg_read && reg_addr == INPUT_VOLTAGE_FLOOR_CONFIG |=>
        reg_rdata == {$past(state.absolute_threshold_select), $past(state.input_voltage_floor)};
  endproperty
  a_config_read: assert property (config_read_prop) // see RULE1
    else $error("floor setting read wrong");

  property absolute_prop;
    @(posedge clk) disable iff (!nrst)
      state.absolute_threshold_select |->
        floor_target_mv == 16'(FLOOR_OFFSET_MV + 16'(state.input_voltage_floor) * FLOOR_STEP_MV);
  endproperty
  a_absolute_mode: assert property (absolute_prop) // see RULE2
    else $error("absolute floor wrong");

  property select_flag_prop;
    @(posedge clk) disable iff (!nrst)
      floor_is_absolute == state.absolute_threshold_select;
  endproperty
  a_select_flag: assert property (select_flag_prop) // see RULE2
    else $error("select flag wrong");

  property floor_range_prop;
    @(posedge clk) disable iff (!nrst)
      state.absolute_threshold_select |->
        floor_target_mv >= FLOOR_OFFSET_MV && floor_target_mv <= 16'(FLOOR_OFFSET_MV + 16'h007F * FLOOR_STEP_MV);
  endproperty
  a_floor_range: assert property (floor_range_prop) // see RULE2
    else $error("absolute floor out of range");

  property write_lands_prop;
    @(posedge clk) disable iff (!nrst)
      floor_write_seq |=> state.absolute_threshold_select == $past(reg_wdata[SELECT_BIT])
                          && state.input_voltage_floor == $past(reg_wdata[CODE_W-1:0]);
  endproperty
  a_write_lands: assert property (write_lands_prop) // see RULE2
    else $error("floor write lost");

  property write_refused_prop;
    @(posedge clk) disable iff (!nrst)
      other_write_seq |=> $stable(state.absolute_threshold_select) && $stable(state.input_voltage_floor);
  endproperty
  a_write_refused: assert property (write_refused_prop) // see RULE2
    else $error("stray write changed the floor");

  property plug_reload_prop;
    @(posedge clk) disable iff (!nrst)
      plug_seq |=> defaults_seq;
  endproperty
  a_plug_reload: assert property (plug_reload_prop) // see RULE3
    else $error("plug reload missing");

  property reload_wins_prop;
    @(posedge clk) disable iff (!nrst)
      defaults_load && reg_write |=> defaults_seq;
  endproperty
  a_reload_wins: assert property (reload_wins_prop) // see RULE8
    else $error("write beat the reload");

  property thermal_read_prop;
    @(posedge clk) disable iff (!nrst)
      reg_read && reg_addr == BATTERY_VOLTAGE_THERMAL_STATUS |=>
        reg_rdata == {$past(thermal_regulation), $past(battery_voltage_code)};
  endproperty
  a_thermal_read: assert property (thermal_read_prop) // see RULE4
    else $error("thermal read wrong");

  property attach_read_prop;
    @(posedge clk) disable iff (!nrst)
      reg_read && reg_addr == INPUT_VOLTAGE_ATTACH_STATUS |=> reg_rdata[7] == $past(input_attached_flag);
  endproperty
  a_attach_read: assert property (attach_read_prop) // see RULE5
    else $error("attach flag wrong");

  property input_code_prop;
    @(posedge clk) disable iff (!nrst)
      reg_read && reg_addr == INPUT_VOLTAGE_ATTACH_STATUS |=> reg_rdata[6:0] == $past(input_voltage_result);
  endproperty
  a_input_code: assert property (input_code_prop) // see RULE6
    else $error("input code wrong");

  property rdata_hold_prop;
    @(posedge clk) disable iff (!nrst)
      !reg_read |=> $stable(reg_rdata);
  endproperty
  a_rdata_holds: assert property (rdata_hold_prop) // see RULE6
    else $error("read data changed without a read");

  property system_code_prop;
    @(posedge clk) disable iff (!nrst)
      reg_read && reg_addr == SYSTEM_VOLTAGE_RESULT |=> reg_rdata == {1'b0, $past(system_voltage_result)};
  endproperty
  a_system_code: assert property (system_code_prop) // see RULE7
    else $error("system code wrong");

  property spare_read_prop;
    @(posedge clk) disable iff (!nrst)
      reg_read && reg_addr == RESERVED_SLOT |=> reg_rdata == RESERVED_READ;
  endproperty
  a_spare_read: assert property (spare_read_prop)
    else $error("reserved read wrong");

  property timer_pulse_prop;
    @(posedge clk) disable iff (!nrst)
      !register_reset |=> !safety_timer_restart;
  endproperty
  a_timer_pulse: assert property (timer_pulse_prop) // see RULE8
    else $error("timer restart without trigger");

  property reg_reset_prop;
    @(posedge clk) disable iff (!nrst)
      register_reset |=> safety_timer_restart && state.input_voltage_floor == FLOOR_RESET;
  endproperty
  a_reg_reset: assert property (reg_reset_prop) // see RULE8
    else $error("register reset failed");
endmodule : charger_monitor_registers
`default_nettype wire

// file: verif/host_bus_model.sv
// host model that drives the register strobes
`default_nettype none
module host_bus_model
  import charger_monitor_pkg::*;
(
  input  wire logic                  clk,
  output logic                       reg_write,
  output logic                       reg_read,
  output logic      [REG_ADDR_W-1:0] reg_addr,
  output logic      [REG_DATA_W-1:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {reg_write, reg_read, reg_addr, reg_wdata} = 18'h0;
  end
  // one access: strobe held for one rising edge, data inverted once released
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {reg_write, reg_read, reg_addr, reg_wdata} = {wr, ~wr, a, d};
    @(negedge clk);
    {reg_write, reg_read, reg_wdata} = {2'b00, ~d};
  endtask : access
endmodule : host_bus_model
`default_nettype wire

// file: verif/test_charger_monitor_registers.sv
// self-checking bench for the charger monitor register slice
`default_nettype none
module test_charger_monitor_registers import charger_monitor_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, register_reset, input_plugged, thermal_regulation, input_attached_flag;
  logic        reg_write, reg_read, floor_is_absolute, safety_timer_restart;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [6:0]  bat, sys, vin, code;
  logic [15:0] rel_mv, floor_target_mv;
  logic [15:0] exp_q[$];
  int          fails = 0, check_count = 0, seed = 53337;
  charger_monitor_registers dut (.clk(clk), .nrst(nrst), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .register_reset(register_reset),
    .input_plugged(input_plugged), .thermal_regulation(thermal_regulation),
    .input_attached_flag(input_attached_flag), .battery_voltage_code(bat), .system_voltage_result(sys),
    .input_voltage_result(vin), .relative_floor_mv(rel_mv), .floor_target_mv(floor_target_mv),
    .floor_is_absolute(floor_is_absolute), .safety_timer_restart(safety_timer_restart));
  host_bus_model host (.clk(clk), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    exp_q.push_back({8'h00, want});
    host.access(1'b0, a, 8'h00);
  endtask : rd
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  // read data is registered at the strobe edge
  always @(posedge clk) begin
    #1;
    if (reg_read === 1'b1) check({8'h00, reg_rdata}, exp_q.pop_front());
  end
  initial begin
    #8000;
    fails++;
    final_report();
  end
  initial begin
    {nrst, register_reset, input_plugged, thermal_regulation, input_attached_flag} = 5'h00;
    {bat, sys, vin, code} = 28'h0;
    rel_mv = 16'($random(seed));
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    check(16'(floor_is_absolute), 16'h0000);
    check(floor_target_mv, rel_mv);
    rd(INPUT_VOLTAGE_FLOOR_CONFIG, {SELECT_RESET, FLOOR_RESET});
    $display("reset defaults done");
    for (int i = 0; i < 4; i++) begin
      code = 7'($random(seed));
      host.access(1'b1, INPUT_VOLTAGE_FLOOR_CONFIG, {1'b1, code});
      check(16'(floor_is_absolute), 16'h0001);
      check(floor_target_mv, FLOOR_OFFSET_MV + 16'(code) * FLOOR_STEP_MV);
      rd(INPUT_VOLTAGE_FLOOR_CONFIG, {1'b1, code});
    end
    input_plugged = 1'b1;
    repeat (3) @(negedge clk);
    rd(INPUT_VOLTAGE_FLOOR_CONFIG, {SELECT_RESET, FLOOR_RESET});
    host.access(1'b1, INPUT_VOLTAGE_FLOOR_CONFIG, {1'b0, code});
    check(floor_target_mv, rel_mv);
    $display("floor select done");
    host.access(1'b1, INPUT_VOLTAGE_FLOOR_CONFIG, 8'hFF);
    register_reset = 1'b1;
    @(negedge clk);
    register_reset = 1'b0;
    check(16'(safety_timer_restart), 16'h0001);
    rd(INPUT_VOLTAGE_FLOOR_CONFIG, {SELECT_RESET, FLOOR_RESET});
    check(16'(safety_timer_restart), 16'h0000);
    host.access(1'b1, INPUT_VOLTAGE_FLOOR_CONFIG, {1'b1, code});
    fork
      host.access(1'b1, INPUT_VOLTAGE_FLOOR_CONFIG, 8'hFF);
      begin
        @(negedge clk);
        register_reset = 1'b1;
        @(negedge clk);
        register_reset = 1'b0;
      end
    join
    rd(INPUT_VOLTAGE_FLOOR_CONFIG, {SELECT_RESET, FLOOR_RESET});
    $display("register reset done");
    for (int i = 0; i < 4; i++) begin
      {thermal_regulation, input_attached_flag} = 2'(i);
      {bat, sys, vin} = 21'($random(seed));
      host.access(1'b1, BATTERY_VOLTAGE_THERMAL_STATUS, 8'hFF);
      rd(BATTERY_VOLTAGE_THERMAL_STATUS, {thermal_regulation, bat});
      rd(SYSTEM_VOLTAGE_RESULT, {1'b0, sys});
      rd(INPUT_VOLTAGE_ATTACH_STATUS, {input_attached_flag, vin});
      rd(RESERVED_SLOT, RESERVED_READ);
      rd(8'h20, UNMAPPED_READ);
    end
    $display("readings done");
    host.access(1'b1, INPUT_VOLTAGE_FLOOR_CONFIG, 8'hFF);
    {nrst, input_plugged} = 2'b00;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    check(16'(floor_is_absolute), 16'h0000);
    check(16'(safety_timer_restart), 16'h0000);
    check(floor_target_mv, rel_mv);
    rd(INPUT_VOLTAGE_FLOOR_CONFIG, {SELECT_RESET, FLOOR_RESET});
    $display("second reset done");
    repeat (2) @(negedge clk);
    final_report();
  end
endmodule : test_charger_monitor_registers
`default_nettype wire
